// *** tb_window_watchdog_regs.sv ***
// Self-checking bench for the watchdog register side.
`timescale 1ns/100ps
`include "window_watchdog_regs.svh"
module tb_window_watchdog_regs;
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic        challenger_mode = 1'b0;
	logic        reg_wr, reg_rd, reg_rvalid, reg_addr_err;
	logic        answer_refresh, answer_good, answer_error;
	logic [5:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, lfsr_challenge_value;
	logic [3:0]  window_period_sel, recovery_window_sel;
	logic [2:0]  window_duty_sel;
	int          bad_count = 0;
	int          num_checks = 0;
	// Free-running 100 MHz clock.
	always #5 clock = ~clock;
	window_watchdog_regs uut (.clock, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .reg_rvalid, .reg_addr_err, .challenger_mode, .window_period_sel,
		.window_duty_sel, .recovery_window_sel, .lfsr_challenge_value, .answer_refresh,
		.answer_good, .answer_error);
	watchdog_host_model host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
	////////////////////////////////////////////////////////////////////////////////
	// Compare one value; four-state equality so an unknown never matches.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Verdict and end of run.
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Defaults on the pins and through the read path; the answer register reads zero.
	task automatic t_reset_values();
		chk({1'b0, window_period_sel, window_duty_sel, 4'h0, recovery_window_sel}, 16'h1a0b);
		chk(lfsr_challenge_value, 16'h5ab2);
		host.rd(`WD_IDX_WINDOW_CONFIG);
		chk(host.last_rd, 16'h320b);
		host.rd(`WD_IDX_RESPONSE);
		chk(host.last_rd, 16'h0000);
	endtask
	// All ones, then only reserved bits: reserved bits must read zero.
	task automatic t_config();
		host.wr(`WD_IDX_WINDOW_CONFIG, 16'hffff);
		host.rd(`WD_IDX_WINDOW_CONFIG);
		chk(host.last_rd, 16'hf70f);
		chk({5'h00, window_period_sel, window_duty_sel, recovery_window_sel}, 16'h07ff);
		host.wr(`WD_IDX_WINDOW_CONFIG, 16'h0880);
		host.rd(`WD_IDX_WINDOW_CONFIG);
		chk(host.last_rd, 16'h0000);
	endtask
	// Seed rewrite seen on the pins and read back.
	task automatic t_seed();
		host.wr(`WD_IDX_LFSR_SEED, 16'h1234);
		host.rd(`WD_IDX_LFSR_SEED);
		chk(host.last_rd, 16'h1234);
		chk({15'h0000, reg_rvalid}, 16'h0001);
		chk(lfsr_challenge_value, 16'h1234);
	endtask
	// Both modes, a right and a spoiled answer each.
	task automatic t_answers();
		for (int i = 0; i < 4; i++) begin
			@(posedge clock) challenger_mode <= i[1];
			host.answer(i[1], 16'h1234, i[0]);
			#1 chk({13'h0000, answer_refresh, answer_good, answer_error},
				{13'h0000, 1'b1, ~i[0], i[0]});
		end
	endtask
	// Unmapped index: a write is ignored, a read gives zero, both pulse the error.
	task automatic t_unmapped();
		host.wr(6'h3f, 16'hffff);
		#1 chk({15'h0000, reg_addr_err}, 16'h0001);
		chk(lfsr_challenge_value, 16'h1234);
		host.rd(6'h3f);
		chk(host.last_rd, 16'h0000);
		chk({15'h0000, reg_addr_err}, 16'h0001);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence, with a second reset in mid-run.
	initial begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		t_reset_values();
		t_config();
		t_seed();
		t_answers();
		t_unmapped();
		@(posedge clock) rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		#1 t_reset_values();
		final_report();
	end
	// Hang guard, far beyond the roughly fifty cycles the run needs.
	initial begin
		#20000;
		bad_count++;
		final_report();
	end
endmodule // tb_window_watchdog_regs

// *** watchdog_answer_check.sv ***
// Expected-answer computation and comparison for one watchdog answer write.
`timescale 1ns/100ps
`include "window_watchdog_regs.svh"

module watchdog_answer_check #(
	parameter int DATA_W = `WD_DATA_W
) (
	// Current challenge and mode.
	input  wire logic [DATA_W-1:0]                   lfsr_value,
	input  wire window_watchdog_pkg::watchdog_mode_type mode,
	// Word written by the host.
	input  wire logic [DATA_W-1:0]                   answer_word,
	// Result.
	output logic      [DATA_W-1:0]                   expected_word,
	output logic                                     answer_match
);

	////////////////////////////////////////////////////////////////////////////////
	// Two extra bits hold the product so the shift cannot lose a bit before the division.
	logic [DATA_W+1:0] scaled;
	logic [DATA_W+1:0] inverted;
	logic [DATA_W-1:0] challenge_answer;

	// Challenger answer: inverse of ((L*4)+6)-4, divided by 4, truncated.
	always_comb begin
		scaled           = ({2'b00, lfsr_value} << `WD_CHAL_MULT_SHIFT) + `WD_CHAL_ADD
			- `WD_CHAL_SUB;
		inverted         = ~scaled;
		challenge_answer = inverted[DATA_W+1:`WD_CHAL_MULT_SHIFT];
	end

	// Pick the expected word for the active mode and compare.
	always_comb begin
		if (mode == window_watchdog_pkg::mode_challenger) begin
			expected_word = challenge_answer;
		end else begin
			expected_word = DATA_W'(`WD_SIMPLE_ANSWER);
		end
		answer_match = (answer_word == expected_word);
	end

endmodule // watchdog_answer_check

// *** watchdog_host_model.sv ***
// Host model: register accesses and watchdog answers toward the device.
`timescale 1ns/100ps
`include "window_watchdog_regs.svh"
module watchdog_host_model (
	// Clock.
	input  wire logic        clock,
	// Register port toward the device.
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [5:0]       reg_addr,
	output logic [15:0]      reg_wdata,
	input  wire logic [15:0] reg_rdata
);
	logic [15:0] last_rd;
	// Bus idle from time zero.
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 6'h00;
		reg_wdata = 16'h0000;
	end
	// One write; the data field is spoiled after release so stale data is never reused.
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// One read; the data is taken at the edge where the valid pulse is sampled high.
	task automatic rd(input logic [5:0] a);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		last_rd = reg_rdata;
	endtask
	// Answer for a refresh; a spoiled answer flips the lowest bit.
	task automatic answer(input logic chal, input logic [15:0] seed, input logic spoil);
		logic [17:0] t;
		t = ~(({2'b00, seed} << 2) + 18'h00006 - 18'h00004);
		wr(`WD_IDX_RESPONSE, (chal ? t[17:2] : 16'h5ab2) ^ {15'h0000, spoil});
	endtask
endmodule // watchdog_host_model

// *** window_watchdog_pkg.sv ***
// Types shared by the watchdog register files.
package window_watchdog_pkg;

	// Answer scheme that the watchdog expects from the host.
	typedef enum logic {
		mode_simple,
		mode_challenger
	} watchdog_mode_type;

	// Verdict on one answer write.
	typedef enum logic [1:0] {
		verdict_none,
		verdict_good,
		verdict_bad
	} answer_verdict_type;

endpackage

// *** window_watchdog_regs.sv ***
// Register side of the window watchdog: configuration, challenge seed and answer check.
`timescale 1ns/100ps
`include "window_watchdog_regs.svh"

// How it works
// - Window period field, four bits, readable and writable, resets to 0011.
// - Window duty field, three bits, readable and writable, resets to 010; bit above reserved.
// - Recovery timing field, four bits, resets to 1011; upper nibble reserved, reads zero.
// - Sixteen-bit challenge value, readable and writable, starts at 5ab2 after reset.
module window_watchdog_regs #(
	parameter int DATA_W = `WD_DATA_W,
	parameter int ADDR_W = `WD_ADDR_W
) (
	// Clock and reset.
	input  wire logic              clock,
	input  wire logic              rstn,
	// Register access from the serial control decoder (data field only).
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	output logic      [DATA_W-1:0] reg_rdata,
	output logic                   reg_rvalid,
	output logic                   reg_addr_err,
	// Answer scheme selection from the device configuration.
	input  wire logic              challenger_mode,
	// Configuration to the watchdog timing logic.
	output logic      [3:0]        window_period_sel,
	output logic      [2:0]        window_duty_sel,
	output logic      [3:0]        recovery_window_sel,
	output logic      [DATA_W-1:0] lfsr_challenge_value,
	// Answer events to the fail-safe state logic.
	output logic                   answer_refresh,
	output logic                   answer_good,
	output logic                   answer_error
);

	////////////////////////////////////////////////////////////////////////////////
	// The field map is laid out for exactly a 16-bit data field.
	// Refused at elaboration, so a wrong width never reaches a netlist.
	if (DATA_W != 16) begin : g_bad_data_w
		$error("window_watchdog_regs: DATA_W must be 16");
	end
	if (ADDR_W < 6) begin : g_bad_addr_w
		$error("window_watchdog_regs: ADDR_W must be at least 6");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register state.
	logic [3:0]        period_r;
	logic [3:0]        period_nxt;
	logic [2:0]        duty_r;
	logic [2:0]        duty_nxt;
	logic [3:0]        recovery_r;
	logic [3:0]        recovery_nxt;
	logic [DATA_W-1:0] lfsr_r;
	logic [DATA_W-1:0] lfsr_nxt;
	logic [DATA_W-1:0] response_r;
	logic [DATA_W-1:0] response_nxt;

	// Read port state.
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	logic              rvalid_r;
	logic              rvalid_nxt;
	logic              addr_err_r;
	logic              addr_err_nxt;

	// Answer event state.
	logic              refresh_r;
	logic              refresh_nxt;
	logic              good_r;
	logic              good_nxt;
	logic              error_r;
	logic              error_nxt;

	// Decode.
	logic              sel_config;
	logic              sel_seed;
	logic              sel_response;
	logic              sel_any;
	logic              answer_match;
	window_watchdog_pkg::watchdog_mode_type mode;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode; the index is compared at full port width.
	always_comb begin
		sel_config   = (reg_addr == ADDR_W'(`WD_IDX_WINDOW_CONFIG));
		sel_seed     = (reg_addr == ADDR_W'(`WD_IDX_LFSR_SEED));
		sel_response = (reg_addr == ADDR_W'(`WD_IDX_RESPONSE));
		sel_any      = sel_config | sel_seed | sel_response;
		mode         = challenger_mode ? window_watchdog_pkg::mode_challenger
			: window_watchdog_pkg::mode_simple;
	end

	////////////////////////////////////////////////////////////////////////////////
	// The check sees the seed as it stands before this cycle's access, so an answer
	// written together with nothing else is judged against the published challenge.
	watchdog_answer_check #(
		.DATA_W (DATA_W)
	) u_check (
		.lfsr_value    (lfsr_r),
		.mode          (mode),
		.answer_word   (reg_wdata),
		.expected_word (),
		.answer_match  (answer_match)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next values of the configuration, seed and response registers.
	always_comb begin
		period_nxt   = period_r;
		duty_nxt     = duty_r;
		recovery_nxt = recovery_r;
		lfsr_nxt     = lfsr_r;
		response_nxt = response_r;
		if (reg_wr && sel_config) begin
			period_nxt   = reg_wdata[`WD_PERIOD_MSB:`WD_PERIOD_LSB];
			duty_nxt     = reg_wdata[`WD_DUTY_MSB:`WD_DUTY_LSB];
			recovery_nxt = reg_wdata[`WD_RECOVERY_MSB:`WD_RECOVERY_LSB];
		end
		if (reg_wr && sel_seed) begin
			lfsr_nxt = reg_wdata;
		end
		if (reg_wr && sel_response) begin
			response_nxt = reg_wdata;
		end
	end

	// Register the configuration state; reset restores the power-on defaults.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			period_r   <= `WD_PERIOD_RST;
			duty_r     <= `WD_DUTY_RST;
			recovery_r <= `WD_RECOVERY_RST;
			lfsr_r     <= `WD_LFSR_RST;
			response_r <= `WD_RESPONSE_RST;
		end else begin
			period_r   <= period_nxt;
			duty_r     <= duty_nxt;
			recovery_r <= recovery_nxt;
			lfsr_r     <= lfsr_nxt;
			response_r <= response_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data: reserved bits and the write-only response read as zero, so a
	// host cannot learn the last answer back from the device.
	always_comb begin
		rdata_nxt    = rdata_r;
		rvalid_nxt   = 1'b0;
		addr_err_nxt = 1'b0;
		if (reg_rd) begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = '0;
			if (sel_config) begin
				rdata_nxt[`WD_PERIOD_MSB:`WD_PERIOD_LSB]     = period_r;
				rdata_nxt[`WD_DUTY_MSB:`WD_DUTY_LSB]         = duty_r;
				rdata_nxt[`WD_RECOVERY_MSB:`WD_RECOVERY_LSB] = recovery_r;
			end else if (sel_seed) begin
				rdata_nxt = lfsr_r;
			end
			addr_err_nxt = !sel_any;
		end
		if (reg_wr && !sel_any) begin
			addr_err_nxt = 1'b1;
		end
	end

	// Register the read port.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rdata_r    <= '0;
			rvalid_r   <= 1'b0;
			addr_err_r <= 1'b0;
		end else begin
			rdata_r    <= rdata_nxt;
			rvalid_r   <= rvalid_nxt;
			addr_err_r <= addr_err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Judge every answer write; the fail-safe logic counts the error pulses.
	always_comb begin
		refresh_nxt = 1'b0;
		good_nxt    = 1'b0;
		error_nxt   = 1'b0;
		if (reg_wr && sel_response) begin
			refresh_nxt = 1'b1;
			good_nxt    = answer_match;
			error_nxt   = !answer_match;
		end
	end

	// Register the answer events as one-cycle pulses.
	always_ff @(posedge clock) begin
		if (!rstn) begin
			refresh_r <= 1'b0;
			good_r    <= 1'b0;
			error_r   <= 1'b0;
		end else begin
			refresh_r <= refresh_nxt;
			good_r    <= good_nxt;
			error_r   <= error_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs straight from the registers.
	assign window_period_sel    = period_r;
	assign window_duty_sel      = duty_r;
	assign recovery_window_sel  = recovery_r;
	assign lfsr_challenge_value = lfsr_r;
	assign reg_rdata            = rdata_r;
	assign reg_rvalid           = rvalid_r;
	assign reg_addr_err         = addr_err_r;
	assign answer_refresh       = refresh_r;
	assign answer_good          = good_r;
	assign answer_error         = error_r;

endmodule // window_watchdog_regs

// *** window_watchdog_regs.svh ***
// Register indices, field positions, reset values and constants of the watchdog register set.
`ifndef WINDOW_WATCHDOG_REGS_SVH
`define WINDOW_WATCHDOG_REGS_SVH

// Register indices on the control interface.
`define WD_ADDR_W              6
`define WD_IDX_WINDOW_CONFIG   6'h0a
`define WD_IDX_LFSR_SEED       6'h0b
`define WD_IDX_RESPONSE        6'h0c

// Width of the data field carried by one register access.
`define WD_DATA_W              16

// Window configuration field positions inside the 16-bit data field.
`define WD_PERIOD_MSB          15
`define WD_PERIOD_LSB          12
`define WD_DUTY_MSB            10
`define WD_DUTY_LSB            8
`define WD_RECOVERY_MSB        3
`define WD_RECOVERY_LSB        0

// Reset values.
`define WD_PERIOD_RST          4'h3
`define WD_DUTY_RST            3'h2
`define WD_RECOVERY_RST        4'hb
`define WD_LFSR_RST            16'h5ab2
`define WD_RESPONSE_RST        16'h0000

// Fixed answer word of the simple watchdog.
`define WD_SIMPLE_ANSWER       16'h5ab2

// Constants of the challenger answer arithmetic.
`define WD_CHAL_MULT_SHIFT     2
`define WD_CHAL_ADD            18'h00006
`define WD_CHAL_SUB            18'h00004

`endif

// *** window_watchdog_regs_asserts.sv ***
// Concurrent checks on the ports of the watchdog register side.
`timescale 1ns/100ps
`include "window_watchdog_regs.svh"
module window_watchdog_regs_asserts #(
	parameter int DATA_W = 16,
	parameter int ADDR_W = 6
) (
	// Clock, reset and register port.
	input wire logic              clock,
	input wire logic              rstn,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              reg_rvalid,
	input wire logic              challenger_mode,
	// Outputs under watch.
	input wire logic [3:0]        window_period_sel,
	input wire logic [2:0]        window_duty_sel,
	input wire logic [3:0]        recovery_window_sel,
	input wire logic [DATA_W-1:0] lfsr_challenge_value,
	input wire logic              answer_refresh,
	input wire logic              answer_good,
	input wire logic              answer_error
);
	// One clock domain; every check pauses while reset is low.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// Writes land one cycle after the taking edge, and nothing else moves the fields.
	a_period_write: assert property (reg_wr && reg_addr == `WD_IDX_WINDOW_CONFIG
		|=> window_period_sel == $past(reg_wdata[15:12])) else $error("period wrong");
	a_duty_write: assert property (reg_wr && reg_addr == `WD_IDX_WINDOW_CONFIG
		|=> window_duty_sel == $past(reg_wdata[10:8])) else $error("duty wrong");
	a_recovery_write: assert property (reg_wr && reg_addr == `WD_IDX_WINDOW_CONFIG
		|=> recovery_window_sel == $past(reg_wdata[3:0])) else $error("recovery wrong");
	a_config_hold: assert property (!(reg_wr && reg_addr == `WD_IDX_WINDOW_CONFIG)
		|=> $stable({window_period_sel, window_duty_sel, recovery_window_sel}))
		else $error("config moved");
	a_seed_write: assert property (reg_wr && reg_addr == `WD_IDX_LFSR_SEED
		|=> lfsr_challenge_value == $past(reg_wdata)) else $error("seed wrong");
	a_seed_read: assert property (reg_rd && reg_addr == `WD_IDX_LFSR_SEED
		|=> reg_rvalid && reg_rdata == $past(lfsr_challenge_value)) else $error("seed read");
	// Every answer write gets exactly one verdict, judged against the active mode.
	a_answer_verdict: assert property (reg_wr && reg_addr == `WD_IDX_RESPONSE
		|=> answer_refresh && answer_good == ($past(reg_wdata) == ($past(challenger_mode)
		? ~$past(lfsr_challenge_value) : 16'h5ab2))) else $error("verdict wrong");
	a_verdict_excl: assert property (answer_refresh |-> answer_good ^ answer_error)
		else $error("verdict not single");
	a_refresh_cause: assert property (answer_refresh
		|-> $past(reg_wr && reg_addr == `WD_IDX_RESPONSE)) else $error("stray refresh");
endmodule // window_watchdog_regs_asserts

bind window_watchdog_regs window_watchdog_regs_asserts #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) chk (
	.clock, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
	.challenger_mode, .window_period_sel, .window_duty_sel, .recovery_window_sel,
	.lfsr_challenge_value, .answer_refresh, .answer_good, .answer_error);
